// ---- core/sie_inline_ecc.sv ----
// Chosen here: the APB register port.
`timescale 1ns/100ps
module sie_inline_ecc
(
	// Clock and reset
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	// APB slave
	input  wire logic                       i_psel,
	input  wire logic                       i_penable,
	input  wire logic                       i_pwrite,
	input  wire logic [15:0]                i_paddr,
	input  wire logic [31:0]                i_pwdata,
	output logic      [31:0]                o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr,
	// Configuration strap
	input  wire logic                       i_bus64,
	// Processor or PCI request
	input  wire logic                       i_req_valid,
	input  wire logic                       i_req_write,
	input  wire logic [sie_pkg::SIE_AW-1:0] i_req_addr,
	input  wire logic [63:0]                i_req_wdata,
	input  wire logic [7:0]                 i_req_be,
	input  wire logic [7:0]                 i_req_par,
	output logic                            o_req_ready,
	output logic                            o_rsp_valid,
	output logic      [63:0]                o_rsp_data,
	output logic      [7:0]                 o_rsp_par,
	// SDRAM data path
	output logic                            o_mem_req,
	output logic                            o_mem_write,
	output logic      [sie_pkg::SIE_AW-1:0] o_mem_addr,
	output logic      [63:0]                o_mem_wdata,
	output logic      [7:0]                 o_mem_wcheck,
	output logic      [7:0]                 o_mem_be,
	input  wire logic                       i_mem_rvalid,
	input  wire logic [63:0]                i_mem_rdata,
	input  wire logic [7:0]                 i_mem_rcheck
);
	import sie_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	sie_state_e         state_ff;
	sie_state_e         nxt_state;
	logic               rmw_ff;
	logic [63:0]        wdata_ff;
	logic [7:0]         be_ff;
	logic [63:0]        rdq_ff;
	logic [7:0]         rchk_ff;
	logic [1:0]         ctl_ff;
	logic [7:0]         en1_ff;
	logic [7:0]         cnt_ff;
	logic [7:0]         trig_ff;
	logic [7:0]         ed1_ff;
	logic [7:0]         ed2_ff;
	logic               pci_err_ff;
	logic [31:0]        cap_hi_ff;
	logic [31:0]        cap_lo_ff;
	logic [7:0]         cap_chk_ff;

	wire  ecc_on = ctl_ff[SIE_CTL_ECC_EN] & i_bus64;
	wire  par_on = ctl_ff[SIE_CTL_PAR_EN];

	////////////////////////////////////////////////////////////////////////////
	// Check and correct
	wire  [7:0]  recalc = sie_code(rdq_ff);
	wire  [7:0]  syn    = ecc_on ? (recalc ^ rchk_ff) : 8'h00;
	logic [63:0] hit;
	genvar gi;
	generate
		for (gi = 0; gi < 64; gi++)
		begin : g_col
			assign hit[gi] = (syn == SIE_COLS[gi*8 +: 8]);
		end
	endgenerate
	wire  in_chk   = (state_ff == SIE_CHK);
	wire  single   = in_chk & (|hit);
	wire  multi    = in_chk & (syn != 8'h00) & ~(|hit);
	wire  [63:0] fixed = multi ? rdq_ff : (rdq_ff ^ hit);
	logic [63:0] merged;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_merge
			assign merged[gi*8 +: 8] = be_ff[gi] ? wdata_ff[gi*8 +: 8] : fixed[gi*8 +: 8];
		end
	endgenerate

	// Incoming processor parity
	wire  take     = (state_ff == SIE_IDLE) & i_req_valid & o_req_ready;
	wire  par_bad  = take & i_req_write & par_on & (sie_par(i_req_wdata) != i_req_par);
	wire  full_wr  = (i_req_be == SIE_BE_FULL) | ~ecc_on;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			SIE_IDLE: if (take) nxt_state = (i_req_write & full_wr) ? SIE_DONE : SIE_RD;
			SIE_RD:   if (i_mem_rvalid) nxt_state = SIE_CHK;
			SIE_CHK:  nxt_state = SIE_DONE;
			SIE_DONE: nxt_state = SIE_IDLE;
			default:  nxt_state = SIE_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_ff    <= SIE_IDLE;
			rmw_ff      <= 1'b0;
			o_req_ready <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			o_req_ready <= (nxt_state == SIE_IDLE) & ~take;
			if (take)
				rmw_ff <= i_req_write & ~full_wr;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wdata_ff <= '0;
			be_ff    <= '0;
			rdq_ff   <= '0;
			rchk_ff  <= '0;
		end
		else
		begin
			if (take)
			begin
				wdata_ff <= i_req_wdata;
				be_ff    <= i_req_be;
			end
			if ((state_ff == SIE_RD) && i_mem_rvalid)
			begin
				rdq_ff  <= i_mem_rdata;
				rchk_ff <= i_mem_rcheck;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory and response outputs
	wire mem_go  = take | (in_chk & rmw_ff);
	wire mem_wr  = (take & i_req_write & full_wr) | (in_chk & rmw_ff);
	wire [63:0] mem_d = take ? i_req_wdata : merged;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_mem_req    <= 1'b0;
			o_mem_write  <= 1'b0;
			o_mem_addr   <= '0;
			o_mem_wdata  <= '0;
			o_mem_wcheck <= '0;
			o_mem_be     <= '0;
		end
		else
		begin
			o_mem_req <= mem_go;
			if (mem_go)
			begin
				o_mem_write  <= mem_wr;
				o_mem_wdata  <= mem_d;
				o_mem_wcheck <= sie_code(mem_d);
				o_mem_be     <= (take & ~mem_wr) | rmw_ff ? SIE_BE_FULL : i_req_be;
			end
			if (take)
				o_mem_addr <= i_req_addr;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_rsp_valid <= 1'b0;
			o_rsp_data  <= '0;
			o_rsp_par   <= '0;
		end
		else
		begin
			o_rsp_valid <= in_chk & ~rmw_ff;
			if (in_chk & ~rmw_ff)
			begin
				o_rsp_data <= fixed;
				o_rsp_par  <= sie_par(fixed);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB decode; access phase always takes two cycles
	wire        acc     = i_psel & i_penable;
	wire        wr_en   = acc & i_pwrite & o_pready;
	wire [15:0] idx     = {2'b00, i_paddr[15:2]};
	wire        hit_pci = (idx == SIE_IDX_PCI_STATUS);
	wire        hit_cnt = (idx == SIE_IDX_SBE_COUNT);
	wire        hit_trg = (idx == SIE_IDX_SBE_TRIGGER);
	wire        hit_en1 = (idx == SIE_IDX_ERR_ENABLE1);
	wire        hit_ed1 = (idx == SIE_IDX_ERR_DETECT1);
	wire        hit_ed2 = (idx == SIE_IDX_ERR_DETECT2);
	wire        hit_ctl = (idx == SIE_IDX_CONTROL);
	wire        hit_chi = (idx == SIE_IDX_CAP_HIGH);
	wire        hit_clo = (idx == SIE_IDX_CAP_LOW);
	wire        hit_cck = (idx == SIE_IDX_CAP_CHECK);
	wire        mapped  = hit_pci | hit_cnt | hit_trg | hit_en1 | hit_ed1 | hit_ed2
	                    | hit_ctl | hit_chi | hit_clo | hit_cck;
	wire [31:0] rd_mux  =
		hit_pci ? {16'h0000, pci_err_ff, 15'h0000} :
		hit_cnt ? {24'h000000, cnt_ff} :
		hit_trg ? {24'h000000, trig_ff} :
		hit_en1 ? {24'h000000, en1_ff} :
		hit_ed1 ? {24'h000000, ed1_ff} :
		hit_ed2 ? {24'h000000, ed2_ff} :
		hit_ctl ? {30'h0000_0000, ctl_ff} :
		hit_chi ? cap_hi_ff :
		hit_clo ? cap_lo_ff :
		hit_cck ? {24'h000000, cap_chk_ff} : 32'h0000_0000;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_pready  <= 1'b0;
			o_prdata  <= '0;
			o_pslverr <= 1'b0;
		end
		else
		begin
			o_pready  <= acc & ~o_pready;
			o_pslverr <= acc & ~o_pready & ~mapped;
			if (acc & ~o_pready)
				o_prdata <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Error counting and flags; a set in the clearing cycle wins
	wire [7:0] cnt_inc  = cnt_ff + SIE_ONE;
	wire       cnt_wr   = wr_en & hit_cnt;
	wire       sbe_rep  = single & (cnt_inc == trig_ff) & en1_ff[SIE_EN1_SBE_TRIG];
	wire       set_any  = sbe_rep | multi | par_bad;
	wire [7:0] clr_ed1  = (wr_en & hit_ed1) ? i_pwdata[7:0] : 8'h00;
	wire [7:0] clr_ed2  = (wr_en & hit_ed2) ? i_pwdata[7:0] : 8'h00;
	wire       clr_pci  = wr_en & hit_pci & i_pwdata[SIE_PCI_ANY_ERR];
	wire [7:0] set_ed1  = ({7'h00, sbe_rep} << SIE_ED1_SBE_TRIG) | ({7'h00, par_bad} << SIE_ED1_WR_PAR);
	wire [7:0] set_ed2  = {7'h00, multi} << SIE_ED2_MULTI;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt_ff     <= SIE_RST_BYTE;
			trig_ff    <= SIE_RST_BYTE;
			en1_ff     <= SIE_RST_ENABLE;
			ctl_ff     <= SIE_RST_CTL;
			ed1_ff     <= SIE_RST_BYTE;
			ed2_ff     <= SIE_RST_BYTE;
			pci_err_ff <= 1'b0;
		end
		else
		begin
			if (single)
				cnt_ff <= cnt_wr ? SIE_ONE : cnt_inc;
			else if (cnt_wr)
				cnt_ff <= SIE_RST_BYTE;
			if (wr_en & hit_trg)
				trig_ff <= i_pwdata[7:0];
			if (wr_en & hit_en1)
				en1_ff <= i_pwdata[7:0];
			if (wr_en & hit_ctl)
				ctl_ff <= i_pwdata[1:0];
			ed1_ff     <= (ed1_ff & ~clr_ed1) | set_ed1;
			ed2_ff     <= (ed2_ff & ~clr_ed2) | set_ed2;
			pci_err_ff <= (pci_err_ff & ~clr_pci) | set_any;
		end
	end

	// Capture source: processor bus on parity errors, memory bus otherwise
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cap_hi_ff  <= '0;
			cap_lo_ff  <= '0;
			cap_chk_ff <= '0;
		end
		else if (set_any)
		begin
			cap_hi_ff  <= par_bad ? i_req_wdata[63:32] : rdq_ff[63:32];
			cap_lo_ff  <= par_bad ? i_req_wdata[31:0] : rdq_ff[31:0];
			cap_chk_ff <= par_bad ? i_req_par : rchk_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_read_taken;
		take && !i_req_write;
	endsequence
	sequence s_read_issued;
		##1 (o_mem_req && !o_mem_write);
	endsequence

	a_read_issue:   assert property (s_read_taken |-> s_read_issued)
		else $error("read not issued to memory");
	a_rsp_latency:  assert property ((state_ff == SIE_RD && i_mem_rvalid && !rmw_ff) |-> ##2 o_rsp_valid)
		else $error("read answer not two cycles after memory data");
	a_clean_pass:   assert property ((in_chk && !rmw_ff && syn == 8'h00) |=> o_rsp_data == $past(rdq_ff))
		else $error("clean data altered");
	a_multi_raw:    assert property ((multi && !rmw_ff) |=> o_rsp_data == $past(rdq_ff) && ed2_ff[SIE_ED2_MULTI])
		else $error("multi-bit read not raw or not flagged");
	a_single_fix:   assert property ((single && !rmw_ff) |=> $countones(o_rsp_data ^ $past(rdq_ff)) == 1)
		else $error("single-bit error not flipped once");
	a_cnt_step:     assert property ((single && !cnt_wr) |=> cnt_ff == 8'($past(cnt_ff) + 8'h01))
		else $error("counter did not step");
	a_cnt_clear:    assert property ((cnt_wr && !single) |=> cnt_ff == 8'h00)
		else $error("counter not cleared by write");
	a_trig_gate:    assert property ((single && !en1_ff[SIE_EN1_SBE_TRIG] && !ed1_ff[SIE_ED1_SBE_TRIG]) |=> !ed1_ff[SIE_ED1_SBE_TRIG])
		else $error("trigger reported while disabled");
	a_rmw_write:    assert property ((in_chk && rmw_ff) |=> o_mem_req && o_mem_write && o_mem_wcheck == sie_code(o_mem_wdata))
		else $error("merge write missing or bad code");
	a_no_wrback:    assert property ((in_chk && !rmw_ff) |=> !o_mem_req)
		else $error("read caused a memory write");
	a_rsp_parity:   assert property (o_rsp_valid |-> o_rsp_par == sie_par(o_rsp_data))
		else $error("bad processor parity");
	a_capture_load: assert property ((multi && !par_bad) |=> cap_lo_ff == 32'($past(rdq_ff)) && cap_chk_ff == $past(rchk_ff))
		else $error("capture not loaded");
endmodule : sie_inline_ecc

// ---- core/sie_pkg.sv ----
package sie_pkg;
	// APB register indices, byte address is four times the index
	localparam logic [15:0] SIE_IDX_PCI_STATUS   = 16'h0006;
	localparam logic [15:0] SIE_IDX_SBE_COUNT    = 16'h00b8;
	localparam logic [15:0] SIE_IDX_SBE_TRIGGER  = 16'h00b9;
	localparam logic [15:0] SIE_IDX_ERR_ENABLE1  = 16'h00c0;
	localparam logic [15:0] SIE_IDX_ERR_DETECT1  = 16'h00c1;
	localparam logic [15:0] SIE_IDX_ERR_DETECT2  = 16'h00c5;
	localparam logic [15:0] SIE_IDX_CONTROL      = 16'h00f0;
	localparam logic [15:0] SIE_IDX_CAP_HIGH     = 16'h0f0c;
	localparam logic [15:0] SIE_IDX_CAP_LOW      = 16'h0f10;
	localparam logic [15:0] SIE_IDX_CAP_CHECK    = 16'h0f14;
	// Field positions
	localparam int SIE_PCI_ANY_ERR   = 15;
	localparam int SIE_ED1_WR_PAR    = 0;
	localparam int SIE_ED1_SBE_TRIG  = 2;
	localparam int SIE_EN1_SBE_TRIG  = 2;
	localparam int SIE_ED2_MULTI     = 3;
	localparam int SIE_CTL_ECC_EN    = 0;
	localparam int SIE_CTL_PAR_EN    = 1;
	// Reset values and other constants
	localparam logic [7:0]  SIE_RST_BYTE   = 8'h00;
	localparam logic [7:0]  SIE_RST_ENABLE = 8'h00;
	localparam logic [1:0]  SIE_RST_CTL    = 2'h0;
	localparam logic [7:0]  SIE_BE_FULL    = 8'hff;
	localparam logic [7:0]  SIE_ONE        = 8'h01;
	localparam int          SIE_AW         = 32;

	typedef enum logic [2:0]
	{
		SIE_IDLE = 3'b000,
		SIE_RD   = 3'b001,
		SIE_CHK  = 3'b011,
		SIE_DONE = 3'b010
	} sie_state_e;

	// Column of the check matrix for each data bit: distinct odd weight >= 3
	function automatic logic [511:0] sie_build_cols();
		logic [511:0] t;
		int           n;
		int           w;
		t = '0;
		n = 0;
		for (int v = 0; v < 256; v++)
		begin
			w = $countones(8'(v));
			if ((w % 2 == 1) && (w >= 3) && (n < 64))
			begin
				t[n*8 +: 8] = 8'(v);
				n++;
			end
		end
		return t;
	endfunction : sie_build_cols

	localparam logic [511:0] SIE_COLS = sie_build_cols();

	function automatic logic [7:0] sie_code(input logic [63:0] d);
		logic [7:0] c;
		c = '0;
		for (int i = 0; i < 64; i++)
			c = c ^ (d[i] ? SIE_COLS[i*8 +: 8] : 8'h00);
		return c;
	endfunction : sie_code

	function automatic logic [7:0] sie_par(input logic [63:0] d);
		logic [7:0] p;
		p = '0;
		for (int i = 0; i < 8; i++)
			p[i] = ^d[i*8 +: 8];
		return p;
	endfunction : sie_par
endpackage : sie_pkg

// ---- dv/sdram_inline_ecc_tb.sv ----
`timescale 1ns/100ps
module sdram_inline_ecc_tb;
	import sie_pkg::*;
	logic        i_clk, i_rst, i_psel, i_penable, i_pwrite, i_bus64;
	logic [15:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata;
	logic        o_pready, o_pslverr;
	logic        i_req_valid, i_req_write, o_req_ready, o_rsp_valid;
	logic [31:0] i_req_addr, o_mem_addr;
	logic [63:0] i_req_wdata, o_rsp_data, o_mem_wdata, i_mem_rdata, flip_d;
	logic [7:0]  i_req_be, i_req_par, o_rsp_par, o_mem_wcheck, o_mem_be, i_mem_rcheck, flip_c;
	logic        o_mem_req, o_mem_write, i_mem_rvalid;
	logic [63:0] rsp_d, d1, d2;
	logic [7:0]  rsp_p;
	logic [31:0] rd;
	logic        err;
	int          mismatches, cmp_count, rsp_lat, wcnt;

	sie_inline_ecc i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_bus64(i_bus64),
		.i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
		.i_req_wdata(i_req_wdata), .i_req_be(i_req_be), .i_req_par(i_req_par),
		.o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
		.o_rsp_par(o_rsp_par), .o_mem_req(o_mem_req), .o_mem_write(o_mem_write),
		.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_wcheck(o_mem_wcheck),
		.o_mem_be(o_mem_be), .i_mem_rvalid(i_mem_rvalid), .i_mem_rdata(i_mem_rdata),
		.i_mem_rcheck(i_mem_rcheck));

	sie_sdram_model i_mem (.i_clk(i_clk), .i_rst(i_rst), .i_mem_req(o_mem_req),
		.i_mem_write(o_mem_write), .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata),
		.i_mem_wcheck(o_mem_wcheck), .i_mem_be(o_mem_be), .o_rvalid(i_mem_rvalid),
		.o_rdata(i_mem_rdata), .o_rcheck(i_mem_rcheck), .i_flip_d(flip_d), .i_flip_c(flip_c));

	////////////////////////////////////////////////////////////////
	// Odd-weight columns, weight three or more, in ascending order
	function automatic logic [7:0] tb_code(input logic [63:0] d);
		logic [7:0] c;
		int         n;
		c = 8'h00;
		n = 0;
		for (int v = 7; v < 256; v++)
			if (($countones(8'(v)) % 2 == 1) && ($countones(8'(v)) >= 3))
			begin
				if ((n < 64) && d[n])
					c = c ^ 8'(v);
				n++;
			end
		return c;
	endfunction : tb_code

	function automatic logic [7:0] tb_par(input logic [63:0] d);
		logic [7:0] p;
		for (int i = 0; i < 8; i++)
			p[i] = ^d[i*8 +: 8];
		return p;
	endfunction : tb_par

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge i_clk);
		i_psel   <= 1'b1;
		i_pwrite <= wr;
		i_paddr  <= {idx[13:0], 2'b00};
		i_pwdata <= wd;
		@(posedge i_clk);
		i_penable <= 1'b1;
		// Ready is judged at the rising edge; data taken at that same edge
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while ((o_pready !== 1'b1) && (n < 50));
		if (n >= 50)
			mismatches++;
		rd  = o_prdata;
		err = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		check(64'(rd), 64'(exp));
	endtask : rchk

	// Holds one request until taken, then waits until the port is ready again
	task automatic req(input logic wr, input logic [63:0] d, input logic [7:0] be,
		input logic [7:0] par);
		int n;
		int k;
		n = 0;
		k = 0;
		// Stale answers must not pass for a missing one
		rsp_d   = 'x;
		rsp_p   = 'x;
		rsp_lat = -1;
		@(posedge i_clk);
		i_req_valid <= 1'b1;
		i_req_write <= wr;
		i_req_wdata <= d;
		i_req_be    <= be;
		i_req_par   <= par;
		@(posedge i_clk);
		while ((o_req_ready !== 1'b1) && (n < 50))
		begin
			@(posedge i_clk);
			n++;
		end
		i_req_valid <= 1'b0;
		do
		begin
			@(posedge i_clk);
			k = (i_mem_rvalid === 1'b1) ? 0 : k + 1;
			if (o_rsp_valid === 1'b1)
			begin
				rsp_d   = o_rsp_data;
				rsp_p   = o_rsp_par;
				rsp_lat = k;
			end
			n++;
		end
		while ((o_req_ready !== 1'b1) && (n < 100));
		if (n >= 100)
			mismatches++;
	endtask : req

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if ((mismatches == 0) && (cmp_count > 0))
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////
	initial
	begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	initial
	begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		report_and_stop();
	end

	initial
	begin
		{i_psel, i_penable, i_pwrite, i_req_valid, i_req_write} = '0;
		{i_paddr, i_pwdata, i_req_addr, i_req_wdata, i_req_be, i_req_par} = '0;
		{flip_d, flip_c, mismatches, cmp_count, rsp_lat} = '0;
		i_bus64 = 1'b1;
		i_rst   = 1'b1;
		d1 = 64'h0123_4567_89ab_cdef;
		d2 = 64'hfeed_cafe_5a5a_a5a5;
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		i_req_addr <= 32'h0000_0048;
		repeat (2) @(posedge i_clk);
		rchk(SIE_IDX_SBE_COUNT, 32'h0000_0000);
		rchk(SIE_IDX_SBE_TRIGGER, 32'h0000_0000);
		rchk(SIE_IDX_ERR_DETECT2, 32'h0000_0000);
		rchk(16'h0100, 32'h0000_0000);
		check(64'(err), 64'h1);
		apb(1'b1, SIE_IDX_CONTROL, 32'h0000_0003);
		req(1'b1, d1, SIE_BE_FULL, tb_par(d1));
		check(64'(i_mem.mem_c[1]), 64'(tb_code(d1)));
		rchk(SIE_IDX_ERR_DETECT1, 32'h0000_0000);
		req(1'b0, d1, SIE_BE_FULL, 8'h00);
		check(rsp_d, d1);
		check(64'(rsp_p), 64'(tb_par(d1)));
		check(64'(rsp_lat), 64'h2);
		wcnt = i_mem.wr_count;
		flip_d <= 64'h0000_0000_0000_0020;
		req(1'b0, d1, SIE_BE_FULL, 8'h00);
		check(rsp_d, d1);
		check(64'(i_mem.wr_count), 64'(wcnt));
		rchk(SIE_IDX_SBE_COUNT, 32'h0000_0001);
		rchk(SIE_IDX_ERR_DETECT1, 32'h0000_0000);
		apb(1'b1, SIE_IDX_SBE_TRIGGER, 32'h0000_0002);
		apb(1'b1, SIE_IDX_ERR_ENABLE1, 32'h0000_0004);
		flip_d <= 64'h0000_0100_0000_0000;
		req(1'b0, d1, SIE_BE_FULL, 8'h00);
		check(rsp_d, d1);
		rchk(SIE_IDX_ERR_DETECT1, 32'h0000_0004);
		rchk(SIE_IDX_PCI_STATUS, 32'h0000_8000);
		rchk(SIE_IDX_CAP_HIGH, d1[63:32] ^ flip_d[63:32]);
		rchk(SIE_IDX_CAP_LOW, d1[31:0]);
		rchk(SIE_IDX_CAP_CHECK, 32'(tb_code(d1)));
		flip_d <= 64'h0000_0000_0000_0006;
		req(1'b0, d1, SIE_BE_FULL, 8'h00);
		check(rsp_d, d1 ^ flip_d);
		rchk(SIE_IDX_ERR_DETECT2, 32'h0000_0008);
		flip_d <= '0;
		apb(1'b1, SIE_IDX_SBE_COUNT, 32'h0000_0055);
		rchk(SIE_IDX_SBE_COUNT, 32'h0000_0000);
		req(1'b1, d2, 8'h0f, tb_par(d2));
		check(i_mem.mem_d[1], {d1[63:32], d2[31:0]});
		check(64'(i_mem.mem_c[1]), 64'(tb_code({d1[63:32], d2[31:0]})));
		apb(1'b1, SIE_IDX_ERR_DETECT1, 32'h0000_0005);
		req(1'b1, d2, SIE_BE_FULL, ~tb_par(d2));
		rchk(SIE_IDX_ERR_DETECT1, 32'h0000_0001);
		rchk(SIE_IDX_CAP_LOW, d2[31:0]);
		rchk(SIE_IDX_CAP_CHECK, {24'h00_0000, ~tb_par(d2)});
		apb(1'b1, SIE_IDX_ERR_DETECT1, 32'h0000_0001);
		apb(1'b1, SIE_IDX_CONTROL, 32'h0000_0001);
		req(1'b1, d2, SIE_BE_FULL, ~tb_par(d2));
		rchk(SIE_IDX_ERR_DETECT1, 32'h0000_0000);
		check(64'(i_mem.mem_c[1]), 64'(tb_code(d2)));
		i_bus64 <= 1'b0;
		flip_d <= 64'h0000_0000_0000_0001;
		req(1'b0, d2, SIE_BE_FULL, 8'h00);
		check(rsp_d, d2 ^ flip_d);
		rchk(SIE_IDX_SBE_COUNT, 32'h0000_0000);
		// Wide bus again, but correction switched off by its own enable
		i_bus64 <= 1'b1;
		apb(1'b1, SIE_IDX_CONTROL, 32'h0000_0000);
		req(1'b0, d2, SIE_BE_FULL, 8'h00);
		check(rsp_d, d2 ^ flip_d);
		rchk(SIE_IDX_SBE_COUNT, 32'h0000_0000);
		report_and_stop();
	end
endmodule : sdram_inline_ecc_tb

// ---- dv/sie_sdram_model.sv ----
`timescale 1ns/100ps
module sie_sdram_model
#(
	parameter int RD_LAT = 2
)
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Memory side of the block
	input  wire logic        i_mem_req,
	input  wire logic        i_mem_write,
	input  wire logic [31:0] i_mem_addr,
	input  wire logic [63:0] i_mem_wdata,
	input  wire logic [7:0]  i_mem_wcheck,
	input  wire logic [7:0]  i_mem_be,
	output logic             o_rvalid,
	output logic      [63:0] o_rdata,
	output logic      [7:0]  o_rcheck,
	// Fault injection from the bench
	input  wire logic [63:0] i_flip_d,
	input  wire logic [7:0]  i_flip_c
);
	logic [63:0] mem_d [8];
	logic [7:0]  mem_c [8];
	logic [2:0]  rd_slot;
	int          wr_count;
	int          wait_cnt;

	// Eight double-word slots are plenty for the bench
	always @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < 8; i++)
			begin
				mem_d[i] = '0;
				mem_c[i] = '0;
			end
			wr_count = 0;
			wait_cnt = 0;
			rd_slot  = '0;
			o_rvalid <= 1'b0;
			o_rdata  <= '0;
			o_rcheck <= '0;
		end
		else
		begin
			o_rvalid <= 1'b0;
			// Released data bus keeps changing so stale data never matches
			o_rdata  <= ~o_rdata;
			o_rcheck <= ~o_rcheck;
			if (wait_cnt == 1)
			begin
				o_rvalid <= 1'b1;
				o_rdata  <= mem_d[rd_slot] ^ i_flip_d;
				o_rcheck <= mem_c[rd_slot] ^ i_flip_c;
			end
			if (wait_cnt > 0)
				wait_cnt = wait_cnt - 1;
			if (i_mem_req && !i_mem_write)
			begin
				wait_cnt = RD_LAT;
				rd_slot  = i_mem_addr[5:3];
			end
			if (i_mem_req && i_mem_write)
			begin
				for (int b = 0; b < 8; b++)
					if (i_mem_be[b])
						mem_d[i_mem_addr[5:3]][b*8 +: 8] = i_mem_wdata[b*8 +: 8];
				mem_c[i_mem_addr[5:3]] = i_mem_wcheck;
				wr_count = wr_count + 1;
			end
		end
	end
endmodule : sie_sdram_model
